// ==== logic/gpr_pkg.sv ====
// package: constants for the remappable gpio port
// What this block does
// [RULE_01] active peripheral drive disables port driver
// [RULE_02] idle enabled peripheral leaves port in control
// [RULE_03] port output never loops into peripheral input; remap_in_o still reads port-driven pins
// [RULE_04] direction bit one means input
// [RULE_05] reset sets all direction bits
// [RULE_06] latch reads latch, writes latch
// [RULE_07] pin register reads pins, writes latch
// [RULE_08] unimplemented bits read as zero
// [RULE_09] each remap input has 5-bit selector
// [RULE_10] lock set silently ignores remap writes
// [RULE_11] lock is oscillator control bit 6
// [RULE_12] software writes 0x46, 0x57, then lock change
// [RULE_13] lock holds until next unlock sequence
// [RULE_14] shadow mismatch raises configuration reset
// [RULE_15] one-way bit stops lock clearing
// [RULE_16] one-way set lock: only reset clears
// [RULE_17] one-way bit defaults set when unprogrammed
// [RULE_18] analog pins after reset read zero
// [RULE_19] software sets analog cfg bits for digital
// [RULE_20] digital output works with analog enabled
// [RULE_21] highest priority function owns the pin
// [RULE_22] input-only sharing is a dedicated port pin
// [RULE_23] key writes must be consecutive before change
package gpr_pkg;
  localparam int          NPIN        = 16;
  localparam int          NSEL        = 8;
  localparam int          SELW        = 5;
  localparam int          NFN         = 2;
  localparam logic [15:0] IMPL_MASK   = 16'h3fff;
  localparam logic [15:0] ANA_MASK    = 16'h003f;
  localparam logic [3:0]  A_DIR       = 4'h0;
  localparam logic [3:0]  A_LAT       = 4'h1;
  localparam logic [3:0]  A_PIN       = 4'h2;
  localparam logic [3:0]  A_OSC       = 4'h3;
  localparam logic [3:0]  A_ANA       = 4'h4;
  localparam logic [3:0]  A_RMP0      = 4'h8;
  localparam int          LOCK_BIT    = 6;
  localparam logic [7:0]  KEY1        = 8'h46;
  localparam logic [7:0]  KEY2        = 8'h57;
  localparam logic [15:0] DIR_RST     = 16'hffff;
  localparam logic [15:0] ANA_RST     = 16'h0000;
  localparam logic [4:0]  SEL_RST     = 5'h1f;
  typedef enum logic [2:0] {
    KS_IDLE = 3'b001,
    KS_K1   = 3'b010,
    KS_K2   = 3'b100
  } gpr_key_e;
endpackage

// ==== logic/gpr_port.sv ====
// module: gpio port with remap selectors and lock sequence
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
module gpr_port (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        one_way_lock_cfg_i,
  input  wire logic [15:0] pin_i,
  output logic      [15:0] pin_o,
  output logic      [15:0] pin_oe_o,
  input  wire logic [31:0] fn_en_i,
  input  wire logic [31:0] fn_drv_i,
  input  wire logic [31:0] fn_out_i,
  output logic      [15:0] fn_in_o,
  output logic      [39:0] remap_in_o,
  output logic             cfg_mismatch_rst_o
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [15:0]   dir;
    logic [15:0]   lat;
    logic [15:0]   ana;
    logic          lock;
    logic          lock_once;
    logic          ow;
    logic          ow_taken;
    gpr_pkg::gpr_key_e ks;
    logic [39:0]   sel;
    logic [39:0]   shadow;
    logic [15:0]   rdata;
    logic          mism;
  } gpr_state_s;

  gpr_state_s s_q, s_d;

  function automatic logic [15:0] impl(input logic [15:0] v);
    impl = v & gpr_pkg::IMPL_MASK;
  endfunction

  // true for the indexes that hold input selectors
  function automatic logic sel_addr(input logic [3:0] a);
    sel_addr = (a >= gpr_pkg::A_RMP0);
  endfunction

  // ==========================================================
  // pin ownership
  logic [15:0] own_fn;
  logic [15:0] fn_val;
  logic [15:0] dig_in;
  always_comb begin
    own_fn = 16'h0000;
    fn_val = 16'h0000;
    for (int p = 0; p < gpr_pkg::NPIN; p++) begin
      // lower index function has higher priority; see [RULE_21]
      for (int f = gpr_pkg::NFN - 1; f >= 0; f--) begin
        if (fn_en_i[f*16+p] && fn_drv_i[f*16+p]) begin
          own_fn[p] = 1'b1; // see [RULE_01] see [RULE_02]
          fn_val[p] = fn_out_i[f*16+p];
        end
      end
    end
  end

  // analog pins read zero digitally; see [RULE_18]
  assign dig_in = impl(pin_i & ~(gpr_pkg::ANA_MASK & ~s_q.ana));

  always_comb begin
    for (int p = 0; p < gpr_pkg::NPIN; p++) begin
      // driver enable ignores analog mode; see [RULE_20] see [RULE_04]
      pin_oe_o[p] = gpr_pkg::IMPL_MASK[p] & (own_fn[p] | ~s_q.dir[p]);
      pin_o[p]    = gpr_pkg::IMPL_MASK[p] &
                    (own_fn[p] ? fn_val[p] : s_q.lat[p]);
      // block port loop-through; see [RULE_03] see [RULE_22]
      fn_in_o[p]  = (~own_fn[p] & ~s_q.dir[p]) ? 1'b0 : dig_in[p];
    end
  end

  // remapped inputs; see [RULE_09]
  always_comb begin
    for (int i = 0; i < gpr_pkg::NSEL; i++) begin
      logic [4:0] sv;
      sv = s_q.sel[i*5 +: 5];
      remap_in_o[i*5 +: 5] = 5'h00;
      remap_in_o[i*5]      = (sv < 5'h10) ? dig_in[sv[3:0]] : 1'b0;
    end
  end

  // ==========================================================
  // registers and lock sequence
  logic [3:0] sel_idx;
  assign sel_idx = addr_i - gpr_pkg::A_RMP0;

  always_comb begin
    s_d = s_q;
    s_d.rdata = 16'h0000;
    if (!s_q.ow_taken) begin
      s_d.ow       = one_way_lock_cfg_i; // see [RULE_17]
      s_d.ow_taken = 1'b1;
    end
    if (wr_i) begin
      s_d.ks = gpr_pkg::KS_IDLE; // see [RULE_23]
      case (addr_i)
        gpr_pkg::A_DIR: s_d.dir = impl(wdata_i);
        gpr_pkg::A_LAT: s_d.lat = impl(wdata_i); // see [RULE_06]
        gpr_pkg::A_PIN: s_d.lat = impl(wdata_i); // see [RULE_07]
        gpr_pkg::A_ANA: s_d.ana = wdata_i & gpr_pkg::ANA_MASK;
        gpr_pkg::A_OSC: begin
          case (s_q.ks)
            gpr_pkg::KS_IDLE:
              if (wdata_i[7:0] == gpr_pkg::KEY1) begin
                s_d.ks = gpr_pkg::KS_K1; // see [RULE_12]
              end
            gpr_pkg::KS_K1:
              if (wdata_i[7:0] == gpr_pkg::KEY2) begin
                s_d.ks = gpr_pkg::KS_K2;
              end else if (wdata_i[7:0] == gpr_pkg::KEY1) begin
                s_d.ks = gpr_pkg::KS_K1;
              end
            gpr_pkg::KS_K2: begin
              // see [RULE_11] see [RULE_15] see [RULE_16]
              if (!(s_q.ow && s_q.lock_once && s_q.lock)) begin
                s_d.lock = wdata_i[gpr_pkg::LOCK_BIT];
                if (wdata_i[gpr_pkg::LOCK_BIT]) begin
                  s_d.lock_once = 1'b1;
                end
              end
            end
            default: s_d.ks = gpr_pkg::KS_IDLE;
          endcase
        end
        default: begin
          // ignored silently while locked; see [RULE_10] see [RULE_13]
          if (sel_addr(addr_i) && !s_q.lock) begin
            s_d.sel[sel_idx[2:0]*5 +: 5]    = wdata_i[4:0];
            s_d.shadow[sel_idx[2:0]*5 +: 5] = wdata_i[4:0];
          end
        end
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        gpr_pkg::A_DIR: s_d.rdata = impl(s_q.dir); // see [RULE_08]
        gpr_pkg::A_LAT: s_d.rdata = impl(s_q.lat);
        gpr_pkg::A_PIN: s_d.rdata = dig_in;
        gpr_pkg::A_ANA: s_d.rdata = s_q.ana;
        gpr_pkg::A_OSC: s_d.rdata = {9'h000, s_q.lock, 6'h00};
        default:
          if (sel_addr(addr_i)) begin
            s_d.rdata = {11'h000, s_q.sel[sel_idx[2:0]*5 +: 5]};
          end
      endcase
    end
    // shadow compare; see [RULE_14]
    s_d.mism = (s_q.sel != s_q.shadow);
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q.dir       <= gpr_pkg::DIR_RST; // see [RULE_05]
      s_q.lat       <= 16'h0000;
      s_q.ana       <= gpr_pkg::ANA_RST;
      s_q.lock      <= 1'b0;
      s_q.lock_once <= 1'b0;
      s_q.ow        <= 1'b1;
      s_q.ow_taken  <= 1'b0;
      s_q.ks        <= gpr_pkg::KS_IDLE;
      s_q.sel       <= {gpr_pkg::NSEL{gpr_pkg::SEL_RST}};
      s_q.shadow    <= {gpr_pkg::NSEL{gpr_pkg::SEL_RST}};
      s_q.rdata     <= 16'h0000;
      s_q.mism      <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o            = s_q.rdata;
  assign cfg_mismatch_rst_o = s_q.mism;

  // ==========================================================
  // checks: lock and key sequence
  a_lock_blocks: assert property ( // see [RULE_10]
    @(posedge mclk_i) disable iff (!rst_n_i)
    (wr_i && sel_addr(addr_i) && s_q.lock) |=> $stable(s_q.sel))
    else $error("remap write changed while locked");

  a_oneway_hold: assert property ( // see [RULE_16]
    @(posedge mclk_i) disable iff (!rst_n_i)
    (s_q.ow && s_q.lock_once && s_q.lock) |=> s_q.lock)
    else $error("one-way lock cleared");

  a_key_order: assert property ( // see [RULE_12]
    @(posedge mclk_i) disable iff (!rst_n_i)
    ($changed(s_q.lock)) |-> $past(s_q.ks) == gpr_pkg::KS_K2)
    else $error("lock changed without keys");

  a_key_abort: assert property ( // see [RULE_23]
    @(posedge mclk_i) disable iff (!rst_n_i)
    (wr_i && addr_i != gpr_pkg::A_OSC) |=> s_q.ks == gpr_pkg::KS_IDLE)
    else $error("key sequence survived other write");

  a_lock_stays: assert property ( // see [RULE_13]
    @(posedge mclk_i) disable iff (!rst_n_i)
    !(wr_i && addr_i == gpr_pkg::A_OSC && s_q.ks == gpr_pkg::KS_K2)
    |=> $stable(s_q.lock))
    else $error("lock moved outside sequence");

  a_lock_read: assert property ( // see [RULE_11]
    @(posedge mclk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == gpr_pkg::A_OSC)
    |=> rdata_o[gpr_pkg::LOCK_BIT] == $past(s_q.lock))
    else $error("lock bit read wrong");

  a_sel_open: assert property ( // see [RULE_13]
    @(posedge mclk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == gpr_pkg::A_RMP0 && !s_q.lock)
    |=> s_q.sel[4:0] == $past(wdata_i[4:0]))
    else $error("unlocked selector write lost");

  a_ow_latched: assert property ( // see [RULE_17]
    @(posedge mclk_i) disable iff (!rst_n_i)
    s_q.ow_taken |=> $stable(s_q.ow))
    else $error("one-way setting moved");

  // ==========================================================
  // checks: shadow compare
  a_mismatch: assert property ( // see [RULE_14]
    @(posedge mclk_i) disable iff (!rst_n_i)
    (s_q.sel != s_q.shadow) |=> cfg_mismatch_rst_o)
    else $error("mismatch not flagged");

  a_shadow_ok: assert property ( // see [RULE_14]
    @(posedge mclk_i) disable iff (!rst_n_i)
    (s_q.sel == s_q.shadow) |=> !cfg_mismatch_rst_o)
    else $error("mismatch without cause");

  // ==========================================================
  // checks: register reads and writes
  a_pin_reads: assert property ( // see [RULE_07]
    @(posedge mclk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == gpr_pkg::A_PIN) |=> rdata_o == $past(dig_in))
    else $error("pin read wrong");

  a_lat_write: assert property ( // see [RULE_07]
    @(posedge mclk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == gpr_pkg::A_PIN)
    |=> s_q.lat == impl($past(wdata_i)))
    else $error("pin write missed latch");

  a_lat_wr: assert property ( // see [RULE_06]
    @(posedge mclk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == gpr_pkg::A_LAT)
    |=> s_q.lat == impl($past(wdata_i)))
    else $error("latch write lost");

  a_lat_read: assert property ( // see [RULE_06]
    @(posedge mclk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == gpr_pkg::A_LAT)
    |=> rdata_o == impl($past(s_q.lat)))
    else $error("latch read wrong");

  a_dir_write: assert property ( // see [RULE_04]
    @(posedge mclk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == gpr_pkg::A_DIR)
    |=> s_q.dir == impl($past(wdata_i)))
    else $error("direction write lost");

  a_unimpl_read: assert property ( // see [RULE_08]
    @(posedge mclk_i) disable iff (!rst_n_i)
    rd_i |=> (rdata_o & ~gpr_pkg::IMPL_MASK) == 16'h0000)
    else $error("unimplemented bit read nonzero");

  // ==========================================================
  // checks: pin ownership
  a_fn_owns: assert property ( // see [RULE_01]
    @(posedge mclk_i) disable iff (!rst_n_i)
    own_fn[0] |-> pin_oe_o[0] && pin_o[0] == fn_val[0])
    else $error("peripheral lost pin");

  a_fn_all: assert property ( // see [RULE_01]
    @(posedge mclk_i) disable iff (!rst_n_i)
    ((own_fn & gpr_pkg::IMPL_MASK) & ((pin_o ^ fn_val) | ~pin_oe_o))
    == 16'h0000)
    else $error("peripheral value not on pin");

  a_port_drive: assert property ( // see [RULE_02]
    @(posedge mclk_i) disable iff (!rst_n_i)
    ((~own_fn & gpr_pkg::IMPL_MASK) & (pin_o ^ s_q.lat)) == 16'h0000)
    else $error("port latch not on pin");

  a_input_off: assert property ( // see [RULE_04]
    @(posedge mclk_i) disable iff (!rst_n_i)
    (pin_oe_o & ~own_fn & s_q.dir) == 16'h0000)
    else $error("input pin driven");

  a_unimpl_pin: assert property ( // see [RULE_08]
    @(posedge mclk_i) disable iff (!rst_n_i)
    ((pin_oe_o | pin_o) & ~gpr_pkg::IMPL_MASK) == 16'h0000)
    else $error("unimplemented pin active");

  a_prio_pick: assert property ( // see [RULE_21]
    @(posedge mclk_i) disable iff (!rst_n_i)
    (fn_en_i[0] && fn_drv_i[0]) |-> pin_o[0] == fn_out_i[0])
    else $error("lower priority function won");

  a_no_loop: assert property ( // see [RULE_03]
    @(posedge mclk_i) disable iff (!rst_n_i)
    (!own_fn[1] && !s_q.dir[1]) |-> !fn_in_o[1])
    else $error("port looped into peripheral");

  a_loop_all: assert property ( // see [RULE_03]
    @(posedge mclk_i) disable iff (!rst_n_i)
    ((~own_fn & ~s_q.dir) & fn_in_o) == 16'h0000)
    else $error("port looped into peripheral input");

  a_shared_read: assert property ( // see [RULE_22]
    @(posedge mclk_i) disable iff (!rst_n_i)
    ((own_fn | s_q.dir) & (fn_in_o ^ dig_in)) == 16'h0000)
    else $error("peripheral input lost pin level");

  // ==========================================================
  // checks: analog pins and remap inputs
  a_analog_zero: assert property ( // see [RULE_18]
    @(posedge mclk_i) disable iff (!rst_n_i)
    !s_q.ana[0] |-> !dig_in[0])
    else $error("analog pin read nonzero");

  a_analog_all: assert property ( // see [RULE_18]
    @(posedge mclk_i) disable iff (!rst_n_i)
    ((gpr_pkg::ANA_MASK & ~s_q.ana) & dig_in) == 16'h0000)
    else $error("analog pins read nonzero");

  a_analog_out: assert property ( // see [RULE_20]
    @(posedge mclk_i) disable iff (!rst_n_i)
    (!s_q.ana[0] && !s_q.dir[0] && !own_fn[0]) |-> pin_oe_o[0])
    else $error("analog pin lost output");

  a_remap_sel: assert property ( // see [RULE_09]
    @(posedge mclk_i) disable iff (!rst_n_i)
    (s_q.sel[4:0] < 5'h10)
    |-> remap_in_o[0] == dig_in[s_q.sel[3:0]])
    else $error("remap input wrong pin");

  a_remap_zero: assert property ( // see [RULE_09]
    @(posedge mclk_i) disable iff (!rst_n_i)
    (remap_in_o & ~40'h0842108421) == 40'h0000000000)
    else $error("remap spare bit set");
endmodule

// ==== bench/gpr_pin_model.sv ====
// model: external pin levels meeting the port driver
`timescale 1ns/1ps
module gpr_pin_model (
  input  wire logic [15:0] pin_o_i,
  input  wire logic [15:0] pin_oe_i,
  input  wire logic [15:0] ext_i,
  output logic      [15:0] pin_i_o
);
  // driven pins show the driver, others the outside level
  assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_i);
endmodule

// ==== bench/gpr_port_tb_top.sv ====
// testbench: gpio port registers, pin paths and remap lock
`timescale 1ns/1ps
module gpr_port_tb_top;
  logic        mclk_i, rst_n_i, wr_i, rd_i, cfg, mis;
  logic [3:0]  addr_i;
  logic [15:0] wdata_i, rdata_o, pin_i, pin_o, pin_oe_o, fn_in_o, ext, v, d;
  logic [31:0] fn_en_i, fn_drv_i, fn_out_i, rs;
  logic [39:0] remap_in_o, e;
  logic [4:0]  sel [8];
  int          err_total, check_count;
  gpr_port gpr_port_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .one_way_lock_cfg_i(cfg), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .fn_en_i(fn_en_i), .fn_drv_i(fn_drv_i),
    .fn_out_i(fn_out_i), .fn_in_o(fn_in_o), .remap_in_o(remap_in_o),
    .cfg_mismatch_rst_o(mis));
  gpr_pin_model gpr_pin_model_i (.pin_o_i(pin_o), .pin_oe_i(pin_oe_o),
    .ext_i(ext), .pin_i_o(pin_i));
  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [39:0] s, input logic [39:0] x);
    check_count++;
    if (s !== x) begin
      err_total++;
      $display("unexpected at %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] dd);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= dd;
    wr_i    <= 1'b1;
    rd_i    <= 1'b0;
  endtask
  task automatic idle;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    wr_i   <= 1'b0;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1;
    q = rdata_o;
  endtask
  task automatic keyseq(input logic [15:0] dd);
    wr(gpr_pkg::A_OSC, 16'h0046);
    wr(gpr_pkg::A_OSC, 16'h0057);
    wr(gpr_pkg::A_OSC, dd);
    idle();
  endtask
  task automatic reset_dut;
    rst_n_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    idle();
  endtask
  task automatic final_report;
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================
  // clock and watchdog
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    final_report();
  end
  // ==========================================
  // main sequence
  initial begin
    {rst_n_i, wr_i, rd_i, cfg} = '0;
    {addr_i, wdata_i, fn_en_i, fn_drv_i, fn_out_i} = '0;
    rs = 32'hbb7ae194;
    ext = rs[15:0];
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(gpr_pkg::A_DIR, v); chk(v, 16'h3fff);
    chk(pin_oe_o, 16'h0000);
    rd(gpr_pkg::A_PIN, v); chk(v, ext & 16'h3fc0);
    chk(remap_in_o, 40'h0);
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      wr(gpr_pkg::A_LAT, rs[15:0]);
      rd(gpr_pkg::A_LAT, v); chk(v, rs[15:0] & 16'h3fff);
      wr(gpr_pkg::A_PIN, rs[31:16]);
      rd(gpr_pkg::A_LAT, v); chk(v, rs[31:16] & 16'h3fff);
    end
    d = rs[31:16] & 16'h3fff;
    wr(gpr_pkg::A_DIR, 16'h0000);
    idle();
    chk(pin_oe_o & 16'h3fff, 16'h3fff);
    chk(pin_o & 16'h3fff, d);
    chk(fn_in_o & 16'h3fff, 16'h0);
    rd(gpr_pkg::A_PIN, v); chk(v, d & 16'h3fc0);
    wr(gpr_pkg::A_ANA, 16'h003f);
    rs = xs(rs);
    fn_out_i <= rs;
    fn_en_i  <= 32'h000f_0ff0;
    fn_drv_i <= 32'h000f_00f0;
    idle();
    e = (rs[15:0] & 16'h00f0) | (rs[31:16] & 16'h000f) | (d & 16'h3f00);
    chk(pin_o & 16'h3fff, e);
    chk(fn_in_o & 16'h3fff, e & 16'h00ff);
    rd(gpr_pkg::A_PIN, v); chk(v, e);
    wr(gpr_pkg::A_DIR, 16'hffff);
    {fn_en_i, fn_drv_i} <= '0;
    e = '0;
    for (int i = 0; i < 8; i++) begin
      rs = xs(rs);
      sel[i] = 5'(rs % 14);
      wr(4'(gpr_pkg::A_RMP0 + i), {11'h0, sel[i]});
    end
    rs = xs(rs);
    ext <= rs[15:0];
    idle();
    for (int i = 0; i < 8; i++) e[i*5] = ext[sel[i]];
    chk(remap_in_o, e);
    keyseq(16'h0040);
    rd(gpr_pkg::A_OSC, v); chk(v[6], 1'b1);
    wr(gpr_pkg::A_RMP0, 16'h0003);
    rd(gpr_pkg::A_RMP0, v); chk(v, {11'h0, sel[0]});
    keyseq(16'h0000);
    wr(gpr_pkg::A_OSC, 16'h0046);
    wr(gpr_pkg::A_LAT, 16'h0000);
    wr(gpr_pkg::A_OSC, 16'h0057);
    wr(gpr_pkg::A_OSC, 16'h0040);
    wr(gpr_pkg::A_RMP0, 16'h0003);
    rd(gpr_pkg::A_OSC, v); chk(v[6], 1'b0);
    rd(gpr_pkg::A_RMP0, v); chk(v, 16'h0003);
    cfg <= 1'b1;
    reset_dut();
    keyseq(16'h0040);
    keyseq(16'h0000);
    rd(gpr_pkg::A_OSC, v); chk(v[6], 1'b1);
    reset_dut();
    rd(gpr_pkg::A_OSC, v); chk(v[6], 1'b0);
    chk(mis, 1'b0);
    final_report();
  end
endmodule
